// ### verif/rsi_reset_state_init_tb_top.sv
// Testbench for the reset state initialiser: source resets, cause flags, low-voltage registers
`timescale 1ns/1ns
`default_nettype none
module rsi_reset_state_init_tb_top;
  import rsi_pkg::*;
  localparam int W = $bits(rsi_init_t);
  logic clock, rstn, osc_wait, standby, opt_sel, lv_c_wr, lv_l_wr, cause_rd, go;
  logic cpu_hold, pc_undef, init_load;
  logic [7:0] lv_data, lv_ctrl, lv_level, cause;
  logic [3:0] len;
  rsi_src_t kind, src;
  rsi_init_t init_values, prev_init;
  int fails, cmp_count;

  rsi_src_model i_rsi_src_model (.clk(clock), .rstn(rstn), .go(go), .kind(kind), .len(len), .src(src));

  rsi_reset_state_init i_rsi_reset_state_init (.CLOCK(clock), .RSTN(rstn), .PIN_RESET(src.pin),
    .POC_RESET(src.power_on_clear), .WDT_RESET(src.wdt), .LVI_RESET(src.low_voltage_detector), .OSC_WAIT(osc_wait),
    .STANDBY(standby), .OPT_WDT_SEL(opt_sel), .LV_CTRL_WR(lv_c_wr), .LV_LEVEL_WR(lv_l_wr),
    .LV_WR_DATA(lv_data), .CAUSE_RD(cause_rd), .CPU_HOLD(cpu_hold), .PC_UNDEFINED(pc_undef),
    .INIT_LOAD(init_load), .INIT_VALUES(init_values), .LOWVOLT_CONTROL_REG(lv_ctrl),
    .LOWVOLT_LEVEL_SELECT(lv_level), .RESET_CAUSE_FLAGS(cause));

  // Clock, 4 ns period
  always #2 clock = ~clock;

  // Expected initial values, non-zero fields set explicitly
  function automatic rsi_init_t exp_init(input logic opt);
    rsi_init_t e;
    e = '0;
    e.watchdog_enable_reg = opt ? RSI_WATCHDOG_ENABLE_REG_OPT1 : RSI_WATCHDOG_ENABLE_REG_OPT0;
    e.async0_rx_buffer = RSI_ONES8;
    e.async0_tx_shift = RSI_ONES8;
    e.async0_mode = RSI_MODE_INIT;
    e.async0_baud_control = RSI_BAUD0_INIT;
    e.async1_rx_buffer = RSI_ONES8;
    e.async1_tx_buffer = RSI_ONES8;
    e.async1_baud_control = RSI_ONES8;
    e.async1_mode = RSI_MODE_INIT;
    e.async1_control = RSI_CTL1_INIT;
    e.irq_mask_flags = {RSI_IRQ_REGS{RSI_ONES8}};
    e.irq_priority_flags = {RSI_IRQ_REGS{RSI_ONES8}};
    return e;
  endfunction

  // Compare and count
  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // Verdict and end of run
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Bounded wait for the hold to drop
  task automatic wait_run;
    int n;
    n = 0;
    while (cpu_hold !== 1'b0 && n < 30) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(cpu_hold, 1'b0, "hold stuck");
  endtask

  // Back-to-back low-voltage register writes
  task automatic lv_wr(input logic [7:0] c, input logic [7:0] l);
    @(posedge clock);
    lv_c_wr <= 1'b1;
    lv_data <= c;
    @(posedge clock);
    lv_c_wr <= 1'b0;
    lv_l_wr <= 1'b1;
    lv_data <= l;
    #1;
    chk(lv_ctrl, c, "lv ctrl write");
    @(posedge clock);
    lv_l_wr <= 1'b0;
    #1;
    chk(lv_level, l, "lv level write");
  endtask

  // One reset from the given sources, checked at acknowledge
  task automatic src_reset(input rsi_src_t k, input logic opt, input logic sb, input logic [7:0] e_lc,
    input logic [7:0] e_ll, input logic [7:0] e_cause, input string name);
    rsi_init_t e;
    e = sb ? prev_init : exp_init(opt);
    @(posedge clock);
    go <= 1'b1;
    kind <= k;
    len <= 4'h3;
    opt_sel <= opt;
    standby <= sb;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1;
    chk(cpu_hold, 1'b1, "hold");
    chk(pc_undef, 1'b1, "pc undefined");
    chk(init_load, !sb, "load");
    chk(init_values, e, "values");
    chk(lv_ctrl, e_lc, "lv ctrl");
    chk(lv_level, e_ll, "lv level");
    chk(cause, e_cause, "cause");
    prev_init = e;
    @(posedge clock);
    #1;
    chk(init_load, 1'b0, "load pulse");
    $display("Test %s done", name);
  endtask

  // Main sequence
  initial begin
    {clock, rstn, osc_wait, standby, opt_sel, lv_c_wr, lv_l_wr, cause_rd, go} = '0;
    {lv_data, len, kind} = '0;
    fails = 0;
    cmp_count = 0;
    prev_init = '0;
    repeat (20) @(posedge clock);
    #1;
    chk(cpu_hold, 1'b1, "hold in reset");
    chk(cause, 8'h00, "cause in reset");
    @(posedge clock);
    rstn <= 1'b1;
    wait_run;
    lv_wr(8'hA5, 8'h3C);
    src_reset(4'h2, 1'b0, 1'b0, 8'h00, 8'h00, 8'h10, "watchdog");
    wait_run;
    lv_wr(8'h5A, 8'hC3);
    src_reset(4'h1, 1'b1, 1'b0, 8'h5A, 8'hC3, 8'h11, "lowvolt");
    wait_run;
    @(posedge clock);
    cause_rd <= 1'b1;
    @(posedge clock);
    cause_rd <= 1'b0;
    #1;
    chk(cause, 8'h00, "cause read");
    src_reset(4'h1, 1'b0, 1'b0, 8'h5A, 8'hC3, 8'h01, "lowvolt again");
    wait_run;
    src_reset(4'h2, 1'b1, 1'b1, 8'h00, 8'h00, 8'h11, "standby");
    wait_run;
    lv_wr(8'h11, 8'h22);
    src_reset(4'h6, 1'b0, 1'b0, 8'h00, 8'h00, 8'h10, "poweron with watchdog");
    wait_run;
    lv_wr(8'h33, 8'h44);
    @(posedge clock);
    osc_wait <= 1'b1;
    src_reset(4'h8, 1'b1, 1'b0, 8'h00, 8'h00, 8'h00, "pin");
    repeat (6) @(posedge clock);
    #1;
    chk(cpu_hold, 1'b1, "hold in osc wait");
    @(posedge clock);
    osc_wait <= 1'b0;
    wait_run;
    close_out;
  end

  // Watchdog against a hang
  initial begin
    #20000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out;
  end
endmodule
`default_nettype wire

// ### verif/rsi_src_model.sv
// Reset source model: raises chosen reset sources for a set number of cycles
`timescale 1ns/1ns
`default_nettype none
module rsi_src_model
  import rsi_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  input wire rsi_src_t kind,
  input wire logic [3:0] len,
  output var rsi_src_t src
);
  logic [3:0] cnt_ff;

  // Sources rise on go and fall after len cycles
  always_ff @(posedge clk) begin
    if (!rstn) begin
      src <= '0;
      cnt_ff <= 4'h0;
    end else if (go) begin
      src <= kind;
      cnt_ff <= len;
    end else if (cnt_ff > 4'h1) begin
      cnt_ff <= cnt_ff - 4'h1;
    end else begin
      src <= '0;
      cnt_ff <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ### verilog/rsi_pkg.sv
// Package for the reset state initialiser: reset values, field layouts and states
package rsi_pkg;
  localparam int RSI_SYNC_CH = 2;
  localparam int RSI_IRQ_REGS = 4;
  localparam logic [7:0] RSI_Z8 = 8'h00;
  localparam logic [15:0] RSI_Z16 = 16'h0000;
  localparam logic [7:0] RSI_ONES8 = 8'hFF;
  localparam logic [7:0] RSI_MODE_INIT = 8'h01;
  localparam logic [7:0] RSI_BAUD0_INIT = 8'h1F;
  localparam logic [7:0] RSI_CTL1_INIT = 8'h16;
  localparam logic [7:0] RSI_WATCHDOG_ENABLE_REG_OPT0 = 8'h1A;
  localparam logic [7:0] RSI_WATCHDOG_ENABLE_REG_OPT1 = 8'h9A;
  localparam int RSI_WDT_BIT = 4;
  localparam int RSI_LVI_BIT = 0;

  typedef enum logic [2:0] {
    RSI_RUN = 3'h1,
    RSI_RESET = 3'h2,
    RSI_WAIT = 3'h4
  } rsi_state_t;

  // Reset sources, all active high levels
  typedef struct packed {
    logic pin;
    logic power_on_clear;
    logic wdt;
    logic low_voltage_detector;
  } rsi_src_t;

  // Initial values handed to the peripheral registers
  typedef struct packed {
    logic [7:0] watchdog_enable_reg;
    logic [15:0] conv_result_wide;
    logic [7:0] conv_result_narrow;
    logic [7:0] conv_mode_reg;
    logic [7:0] conv_channel_select;
    logic [7:0] conv_port_config;
    logic [7:0] async0_rx_buffer;
    logic [7:0] async0_tx_shift;
    logic [7:0] async0_mode;
    logic [7:0] async0_error_status;
    logic [7:0] async0_baud_control;
    logic [7:0] async1_rx_buffer;
    logic [7:0] async1_tx_buffer;
    logic [7:0] async1_mode;
    logic [7:0] async1_error_status;
    logic [7:0] async1_tx_status;
    logic [7:0] async1_clock_select;
    logic [7:0] async1_baud_control;
    logic [7:0] async1_control;
    logic [7:0] input_switch_control;
    logic [RSI_SYNC_CH-1:0][7:0] sync_tx_buffer;
    logic [RSI_SYNC_CH-1:0][7:0] sync_shift_reg;
    logic [RSI_SYNC_CH-1:0][7:0] sync_mode_reg;
    logic [RSI_SYNC_CH-1:0][7:0] sync_clock_select;
    logic [7:0] twowire_shift;
    logic [7:0] twowire_control;
    logic [7:0] twowire_own_address;
    logic [7:0] twowire_clock_select;
    logic [7:0] twowire_function_expand;
    logic [7:0] twowire_status;
    logic [7:0] twowire_flags;
    logic [7:0] display_mode_setting;
    logic [7:0] display_mode_reg;
    logic [7:0] display_clock_control;
    logic [7:0] display_boost_control;
    logic [15:0] muldiv_remainder;
    logic [15:0] muldiv_operand_a;
    logic [15:0] muldiv_operand_b;
    logic [7:0] muldiv_control;
    logic [7:0] key_return_mode;
    logic [RSI_IRQ_REGS-1:0][7:0] irq_request_flags;
    logic [RSI_IRQ_REGS-1:0][7:0] irq_mask_flags;
    logic [RSI_IRQ_REGS-1:0][7:0] irq_priority_flags;
    logic [7:0] ext_rise_edge_enable;
    logic [7:0] ext_fall_edge_enable;
  } rsi_init_t;
endpackage

// ### verilog/rsi_reset_state_init.sv
// Reset state initialiser: sequencing, peripheral initial values, retained cause flags
//
// Operation
// - During reset or oscillation wait only the program counter is undefined.
// - A reset taken in standby keeps the previous initial values; no values are loaded.
// - Watchdog enable loads one of two values chosen by the option byte.
// - Low-voltage registers clear on pin, power-on or watchdog reset; held otherwise.
// - First async unit: buffers all ones, mode 01H, errors zero, baud 1FH.
// - Second async unit: buffers and baud FFH, mode 01H, control 16H, others zero.
// - Interrupt masks and priorities FFH; requests and edge enables cleared.
// - Converter results and mode, channel and port registers cleared.
// - Each clocked serial channel's buffer, shift, mode, clock registers cleared.
// - Two-wire unit shift, control, address, clock, expand, status, flags cleared.
// - Display mode, display-mode, clock and boost registers cleared.
// - Multiplier remainder, operands and control cleared.
// - Key-return mode register cleared.
// - Reset cause register base value zero; bits follow the reset source.
// - Watchdog flag set by watchdog, cleared by pin/power-on; low-voltage flag likewise.
// - Reading the cause register, pin or power-on reset clears it.
`timescale 1ns/1ns
`default_nettype none
module rsi_reset_state_init
  import rsi_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PIN_RESET,
  input wire logic POC_RESET,
  input wire logic WDT_RESET,
  input wire logic LVI_RESET,
  input wire logic OSC_WAIT,
  input wire logic STANDBY,
  input wire logic OPT_WDT_SEL,
  input wire logic LV_CTRL_WR,
  input wire logic LV_LEVEL_WR,
  input wire logic [7:0] LV_WR_DATA,
  input wire logic CAUSE_RD,
  output logic CPU_HOLD,
  output logic PC_UNDEFINED,
  output logic INIT_LOAD,
  output rsi_init_t INIT_VALUES,
  output logic [7:0] LOWVOLT_CONTROL_REG,
  output logic [7:0] LOWVOLT_LEVEL_SELECT,
  output logic [7:0] RESET_CAUSE_FLAGS
);

  typedef struct packed {
    rsi_state_t state;
    logic load;
    rsi_init_t init;
    logic [7:0] lowvolt_control_reg;
    logic [7:0] lowvolt_level_select;
    logic [7:0] cause;
  } rsi_regs_t;

  rsi_regs_t st_ff;
  rsi_regs_t nxt_st;
  rsi_src_t src;
  logic any_src;
  logic ack;
  logic clr_src;
  rsi_init_t rst_vals;

  // Source bundle and acknowledge detection
  assign src = '{pin: PIN_RESET, power_on_clear: POC_RESET, wdt: WDT_RESET, low_voltage_detector: LVI_RESET};
  assign any_src = src.pin | src.power_on_clear | src.wdt | src.low_voltage_detector;
  assign ack = (st_ff.state == RSI_RUN) && any_src;
  assign clr_src = src.pin | src.power_on_clear;

  // Table of initial values; unlisted fields stay zero
  always_comb begin
    rst_vals = '0;
    rst_vals.watchdog_enable_reg = OPT_WDT_SEL ? RSI_WATCHDOG_ENABLE_REG_OPT1 : RSI_WATCHDOG_ENABLE_REG_OPT0;
    rst_vals.conv_result_wide = RSI_Z16;
    rst_vals.async0_rx_buffer = RSI_ONES8;
    rst_vals.async0_tx_shift = RSI_ONES8;
    rst_vals.async0_mode = RSI_MODE_INIT;
    rst_vals.async0_error_status = RSI_Z8;
    rst_vals.async0_baud_control = RSI_BAUD0_INIT;
    rst_vals.async1_rx_buffer = RSI_ONES8;
    rst_vals.async1_tx_buffer = RSI_ONES8;
    rst_vals.async1_mode = RSI_MODE_INIT;
    rst_vals.async1_baud_control = RSI_ONES8;
    rst_vals.async1_control = RSI_CTL1_INIT;
    rst_vals.muldiv_remainder = RSI_Z16;
    rst_vals.muldiv_operand_a = RSI_Z16;
    rst_vals.muldiv_operand_b = RSI_Z16;
    for (int i = 0; i < RSI_IRQ_REGS; i++) begin
      rst_vals.irq_mask_flags[i] = RSI_ONES8;
      rst_vals.irq_priority_flags[i] = RSI_ONES8;
      rst_vals.irq_request_flags[i] = RSI_Z8;
    end
    rst_vals.ext_rise_edge_enable = RSI_Z8;
    rst_vals.ext_fall_edge_enable = RSI_Z8;
  end

  // Next-state logic for sequencer, retained registers and cause flags
  always_comb begin
    nxt_st = st_ff;
    nxt_st.load = 1'b0;
    case (st_ff.state)
      RSI_RUN: begin
        if (any_src) begin
          nxt_st.state = RSI_RESET;
        end
      end
      RSI_RESET: begin
        if (!any_src) begin
          nxt_st.state = OSC_WAIT ? RSI_WAIT : RSI_RUN;
        end
      end
      RSI_WAIT: begin
        if (any_src) begin
          nxt_st.state = RSI_RESET;
        end else if (!OSC_WAIT) begin
          nxt_st.state = RSI_RUN;
        end
      end
      default: begin
        nxt_st.state = RSI_RESET;
      end
    endcase
    // Software writes to the low-voltage registers outside reset
    if (st_ff.state == RSI_RUN && !any_src) begin
      if (LV_CTRL_WR) begin
        nxt_st.lowvolt_control_reg = LV_WR_DATA;
      end
      if (LV_LEVEL_WR) begin
        nxt_st.lowvolt_level_select = LV_WR_DATA;
      end
    end
    // Read clears the cause register
    if (CAUSE_RD) begin
      nxt_st.cause = RSI_Z8;
    end
    // Acknowledge: load initial values unless in standby; the whole acknowledge cause update wins over read clear
    if (ack) begin
      if (!STANDBY) begin
        nxt_st.init = rst_vals;
        nxt_st.load = 1'b1;
      end
      if (clr_src || src.wdt) begin
        nxt_st.lowvolt_control_reg = RSI_Z8;
        nxt_st.lowvolt_level_select = RSI_Z8;
      end
      nxt_st.cause = clr_src ? RSI_Z8 : st_ff.cause;
      if (src.wdt) begin
        nxt_st.cause[RSI_WDT_BIT] = 1'b1;
      end
      if (src.low_voltage_detector) begin
        nxt_st.cause[RSI_LVI_BIT] = 1'b1;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      st_ff.state <= RSI_RESET;
      st_ff.load <= 1'b0;
      st_ff.init <= '0;
      st_ff.lowvolt_control_reg <= RSI_Z8;
      st_ff.lowvolt_level_select <= RSI_Z8;
      st_ff.cause <= RSI_Z8;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign CPU_HOLD = (st_ff.state != RSI_RUN);
  assign PC_UNDEFINED = CPU_HOLD;
  assign INIT_LOAD = st_ff.load;
  assign INIT_VALUES = st_ff.init;
  assign LOWVOLT_CONTROL_REG = st_ff.lowvolt_control_reg;
  assign LOWVOLT_LEVEL_SELECT = st_ff.lowvolt_level_select;
  assign RESET_CAUSE_FLAGS = st_ff.cause;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  sequence seq_ack;
    (st_ff.state == RSI_RUN) && any_src;
  endsequence

  sequence seq_ack_live;
    seq_ack ##0 !STANDBY;
  endsequence

  chk_hold_during_reset: assert property (seq_ack |=> CPU_HOLD && PC_UNDEFINED)
    else $error("hold not raised after reset acknowledge");
  chk_hold_in_wait: assert property (CPU_HOLD && !any_src && OSC_WAIT |=> CPU_HOLD)
    else $error("hold dropped during oscillation wait");
  chk_standby_keeps: assert property (seq_ack ##0 STANDBY |=> !INIT_LOAD && $stable(INIT_VALUES))
    else $error("values loaded on standby reset");
  chk_watchdog_enable_reg_option: assert property (seq_ack_live |=> INIT_LOAD &&
      INIT_VALUES.watchdog_enable_reg == ($past(OPT_WDT_SEL) ? RSI_WATCHDOG_ENABLE_REG_OPT1 : RSI_WATCHDOG_ENABLE_REG_OPT0))
    else $error("watchdog enable initial value wrong");
  chk_lv_cleared: assert property (seq_ack ##0 (clr_src || src.wdt) |=> LOWVOLT_CONTROL_REG == RSI_Z8 &&
      LOWVOLT_LEVEL_SELECT == RSI_Z8)
    else $error("low-voltage registers not cleared");
  chk_lv_held: assert property (seq_ack ##0 !(clr_src || src.wdt) |=> $stable(LOWVOLT_CONTROL_REG) &&
      $stable(LOWVOLT_LEVEL_SELECT))
    else $error("low-voltage registers not held");
  chk_async_values: assert property (seq_ack_live |=> INIT_VALUES.async0_baud_control == RSI_BAUD0_INIT &&
      INIT_VALUES.async0_mode == RSI_MODE_INIT && INIT_VALUES.async1_control == RSI_CTL1_INIT &&
      INIT_VALUES.async1_baud_control == RSI_ONES8 && INIT_VALUES.async0_tx_shift == RSI_ONES8)
    else $error("async unit initial values wrong");
  chk_irq_values: assert property (seq_ack_live |=> INIT_VALUES.irq_mask_flags[0] == RSI_ONES8 &&
      INIT_VALUES.irq_priority_flags[RSI_IRQ_REGS-1] == RSI_ONES8 &&
      INIT_VALUES.irq_request_flags[0] == RSI_Z8 && INIT_VALUES.ext_fall_edge_enable == RSI_Z8)
    else $error("interrupt initial values wrong");
  chk_zero_groups: assert property (seq_ack_live |=> INIT_VALUES.conv_result_wide == RSI_Z16 &&
      INIT_VALUES.sync_mode_reg == '0 && INIT_VALUES.twowire_control == RSI_Z8 &&
      INIT_VALUES.display_boost_control == RSI_Z8 && INIT_VALUES.muldiv_operand_b == RSI_Z16 &&
      INIT_VALUES.key_return_mode == RSI_Z8)
    else $error("zeroed register initial values wrong");
  chk_wdt_cause: assert property (seq_ack ##0 src.wdt |=> RESET_CAUSE_FLAGS[RSI_WDT_BIT])
    else $error("watchdog cause flag not set");
  chk_pin_clears: assert property (seq_ack ##0 clr_src && !src.low_voltage_detector && !src.wdt
      |=> RESET_CAUSE_FLAGS == RSI_Z8)
    else $error("pin reset did not clear cause flags");
  chk_read_clears: assert property (CAUSE_RD && !ack |=> RESET_CAUSE_FLAGS == RSI_Z8)
    else $error("cause read did not clear flags");
  chk_load_pulse: assert property (INIT_LOAD |-> CPU_HOLD ##1 !INIT_LOAD)
    else $error("initial load longer than one cycle");
endmodule
`default_nettype wire
